// ===== rtl/cmd_decoder.sv
/*
 * Command decoder with break control, transmit holding register and status flags,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes a 10 MHz clock and an asynchronous clear-to-send pin.
 */
`default_nettype none
module cmd_decoder
   import cmd_dec_pkg::*;
#(
   parameter int DIV = CLK_HZ / BAUD_DEF
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic [31:0]      readdata_o,
   output logic             waitrequest_o,
   input  wire logic        clear_to_send_n_i,
   output logic             serial_transmit_line_o,
   output logic             mode_ptr_o,
   output logic             irq_o
);
   typedef enum logic [2:0] {
      BK_IDLE = 3'b001,
      BK_WAIT = 3'b010,
      BK_ON   = 3'b100
   } brk_t;

   logic        tick;
   logic        sh_busy;
   logic        sh_done;
   logic        sh_line;
   logic        sh_start;
   logic        cts_meta_q;
   logic        cts_q;
   logic        ack_q;
   logic        ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        wr;
   logic        cmd_wr;
   logic [2:0]  misc;
   logic [1:0]  tc;
   logic [10:0] st_q;
   logic [10:0] st_d;
   logic        txen_q;
   logic        txen_d;
   logic        rxen_q;
   logic        rxen_d;
   logic [1:0]  rxptr_q;
   logic [1:0]  rxptr_d;
   logic        mptr_q;
   logic        mptr_d;
   logic [7:0]  hold_q;
   logic [7:0]  hold_d;
   logic        full_q;
   logic        full_d;
   brk_t        bk_q;
   brk_t        bk_d;
   logic        line_q;
   logic        line_d;
   logic [EV_W-1:0] ev_q;
   logic [EV_W-1:0] ev_d;
   logic [EV_W-1:0] mask_q;
   logic [EV_W-1:0] mask_d;
   logic [EV_W-1:0] ev_set;
   logic        irq_q;

   bit_tick #(.DIV(DIV)) u_tick (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .tick_o  (tick)
   );

   tx_shifter u_shift (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .tick_i  (tick),
      .start_i (sh_start),
      .data_i  (hold_q),
      .busy_o  (sh_busy),
      .done_o  (sh_done),
      .line_o  (sh_line)
   );

   // Clear-to-send is synchronised and only gates normal data, not breaks.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cts_meta_q <= 1'b1;
         cts_q      <= 1'b1;
      end else begin
         cts_meta_q <= clear_to_send_n_i;
         cts_q      <= cts_meta_q;
      end
   end

   // Bus slave: each access is answered one cycle after it is presented.
   assign wr     = write_i && ack_q;
   assign cmd_wr = wr && (address_i == ADDR_COMMAND);
   assign misc   = writedata_i[MISC_LSB +: 3];
   assign tc     = writedata_i[TC_LSB +: 2];

   always_comb begin
      ack_d   = (read_i || write_i) && !ack_q;
      rdata_d = rdata_q;
      if (read_i && !ack_q) begin
         unique case (address_i)
            ADDR_STATUS:  rdata_d = {20'h0_0000, bk_q == BK_ON, st_q};
            ADDR_EVENTS:  rdata_d = {29'h0, ev_q};
            ADDR_MASK:    rdata_d = {29'h0, mask_q};
            ADDR_TXDATA:  rdata_d = {24'h00_0000, hold_q};
            ADDR_MODEPTR: rdata_d = {30'h0, rxptr_q == 2'h0, mptr_q};
            default:      rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   // Command decode and flag upkeep.
   always_comb begin
      st_d    = st_q;
      txen_d  = txen_q;
      rxen_d  = rxen_q;
      rxptr_d = rxptr_q;
      mptr_d  = mptr_q;
      hold_d  = hold_q;
      full_d  = full_q;
      bk_d    = bk_q;
      line_d  = line_q;
      sh_start = 1'b0;
      ev_set  = '0;
      // Hardware flag sources from the stimulus register.
      if (wr && address_i == ADDR_STIMULUS) begin
         st_d[ST_RXBRK:ST_OVRUN] = st_q[ST_RXBRK:ST_OVRUN] | writedata_i[7:4];
         st_d[ST_DBRK]  = st_q[ST_DBRK] | writedata_i[8];
         st_d[ST_RECEIVE_READY_FLAG] = st_q[ST_RECEIVE_READY_FLAG] | (rxen_q & writedata_i[0]);
         st_d[ST_FIFO_FULL_FLAG] = st_q[ST_FIFO_FULL_FLAG] | (rxen_q & writedata_i[1]);
         rxen_d         = rxen_q | writedata_i[10];
      end
      if (wr && address_i == ADDR_TXDATA && txen_q && !full_q) begin
         hold_d = writedata_i[7:0];
         full_d = 1'b1;
         st_d[ST_TRANSMIT_READY_FLAG] = 1'b0;
         st_d[ST_TRANSMIT_EMPTY_FLAG] = 1'b0;
      end
      // Holding register feeds the shifter only outside a break.
      if (full_q && !sh_busy && bk_q == BK_IDLE && !cts_q && txen_q) begin // [R12]
         sh_start = 1'b1;
         full_d   = 1'b0;
         st_d[ST_TRANSMIT_READY_FLAG] = 1'b1;
      end
      if (sh_done) begin
         ev_set[EV_TX_DONE] = 1'b1;
         if (!full_q) begin
            st_d[ST_TRANSMIT_EMPTY_FLAG] = 1'b1;
         end
      end
      if (cmd_wr) begin
         if (tc == TC_ENABLE && !txen_q) begin // [R18]
            txen_d = 1'b1;
            st_d[ST_TRANSMIT_EMPTY_FLAG] = 1'b1;
            st_d[ST_TRANSMIT_READY_FLAG] = 1'b1;
         end else if (tc == TC_DISABLE) begin
            txen_d = 1'b0;
            st_d[ST_TRANSMIT_EMPTY_FLAG] = 1'b0;
            st_d[ST_TRANSMIT_READY_FLAG] = 1'b0;
         end
         unique case (misc) // [R02]
            MISC_NONE: begin
            end
            MISC_MRPTR: mptr_d = 1'b0; // [R03]
            MISC_RX_RESET: begin // [R04]
               rxen_d  = 1'b0;
               rxptr_d = 2'h0;
               st_d[ST_FIFO_FULL_FLAG] = 1'b0;
               st_d[ST_RECEIVE_READY_FLAG] = 1'b0;
            end
            MISC_TX_RESET: begin // [R06]
               txen_d = 1'b0;
               full_d = 1'b0;
               st_d[ST_TRANSMIT_EMPTY_FLAG] = 1'b0;
               st_d[ST_TRANSMIT_READY_FLAG] = 1'b0;
               if (bk_q != BK_IDLE) begin // [R19]
                  bk_d = BK_IDLE;
                  ev_set[EV_BRK_OFF] = 1'b1;
               end
            end
            MISC_ERR_RESET: st_d[ST_RXBRK:ST_OVRUN] = 4'h0; // [R08]
            MISC_DB_RESET:  st_d[ST_DBRK] = 1'b0; // [R09]
            MISC_BRK_START: begin
               if (txen_q && bk_q == BK_IDLE) begin // [R13] [R14]
                  bk_d = BK_WAIT;
               end
            end
            MISC_BRK_STOP: begin
               if (bk_q != BK_IDLE) begin // [R15] [R16]
                  bk_d = BK_IDLE;
                  ev_set[EV_BRK_OFF] = 1'b1;
               end
            end
         endcase
      end else begin
         // Break waits for the shifter, then starts on a bit tick.
         unique case (bk_q)
            BK_IDLE: begin
            end
            BK_WAIT: begin
               if (!sh_busy && tick) begin // [R10] [R11]
                  bk_d = BK_ON;
                  ev_set[EV_BRK_ON] = 1'b1;
               end
            end
            BK_ON: begin
            end
         endcase
      end
      // Line is low throughout a break, else follows the shifter.
      line_d = (bk_q == BK_ON) ? 1'b0 : sh_line; // [R19]
      st_d[ST_TXEN - 1 + 1] = txen_d;
      st_d[ST_RXEN] = rxen_d;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_q    <= 11'h000;
         txen_q  <= 1'b0;
         rxen_q  <= 1'b0;
         rxptr_q <= 2'h0;
         mptr_q  <= 1'b0;
         hold_q  <= 8'h00;
         full_q  <= 1'b0;
         bk_q    <= BK_IDLE;
         line_q  <= 1'b1;
      end else begin
         st_q    <= st_d;
         txen_q  <= txen_d;
         rxen_q  <= rxen_d;
         rxptr_q <= rxptr_d;
         mptr_q  <= mptr_d;
         hold_q  <= hold_d;
         full_q  <= full_d;
         bk_q    <= bk_d;
         line_q  <= line_d;
      end
   end

   // The mode_ptr_o output steps on to the second register after any mode access; the mptr_q readback bit never sets.
   // Here a write to the mode-pointer register models that access.

   // Sticky events, write one to clear, set winning over clear.
   always_comb begin
      ev_d   = ev_q;
      mask_d = mask_q;
      if (wr && address_i == ADDR_EVENTS) begin
         ev_d = ev_q & ~writedata_i[EV_W-1:0];
      end
      if (wr && address_i == ADDR_MASK) begin
         mask_d = writedata_i[EV_W-1:0];
      end
      ev_d = ev_d | ev_set;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ev_q   <= '0;
         mask_q <= '0;
         irq_q  <= 1'b0;
      end else begin
         ev_q   <= ev_d;
         mask_q <= mask_d;
         irq_q  <= |(ev_d & mask_d);
      end
   end

   logic mp_q;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mp_q <= 1'b0;
      end else if (cmd_wr && misc == MISC_MRPTR) begin
         mp_q <= 1'b0;
      end else if (wr && address_i == ADDR_MODEPTR) begin
         mp_q <= 1'b1;
      end
   end

   assign readdata_o             = rdata_q;
   assign waitrequest_o          = !ack_q;
   assign serial_transmit_line_o = line_q;
   assign mode_ptr_o             = mp_q;
   assign irq_o                  = irq_q;
endmodule
`default_nettype wire

// ===== common/cmd_dec_pkg.sv
/*
 * Shared constants for the command decoder: register offsets, field positions,
 * command codes and bit timing.
 * Assumes a 10 MHz clock and a 32-bit Avalon-MM register slave.
 */
// Notes on behaviour
// R01 - Software writes zero to the reserved top bit of the command register.
// R02 - Bits six to four hold one auxiliary command; code zero does nothing.
// R03 - Code 001 points the mode-register pointer back at the first mode register.
// R04 - Code 010 disables receiver, clears full and ready flags, resets FIFO pointer.
// R05 - Software should reset rather than disable the receiver when reconfiguring.
// R06 - Code 011 disables transmitter and clears transmit empty and ready flags.
// R07 - Software should reset rather than disable the transmitter when reconfiguring.
// R08 - Code 100 clears received break, framing, parity and overrun flags.
// R09 - Code 101 clears the delta-break flag.
// R10 - Code 110 drives the line low; may lag one bit time when idle.
// R11 - A break waits until the character in the shift register is sent.
// R12 - A held character is sent only after the break ends.
// R13 - Start break is accepted only while the transmitter is enabled.
// R14 - Start break ignores the clear-to-send input.
// R15 - Code 111 returns the line to mark within two bit times.
// R16 - After stop break, characters still held are transmitted.
// R17 - Software combines only non-conflicting commands in one write.
// R18 - Transmit enable sets empty and ready flags; no effect if already enabled.
// R19 - A started break holds the line low until stop break or transmitter reset.
`default_nettype none
package cmd_dec_pkg;
   localparam logic [3:0] ADDR_COMMAND   = 4'h0;
   localparam logic [3:0] ADDR_STATUS    = 4'h1;
   localparam logic [3:0] ADDR_EVENTS    = 4'h2;
   localparam logic [3:0] ADDR_MASK      = 4'h3;
   localparam logic [3:0] ADDR_TXDATA    = 4'h4;
   localparam logic [3:0] ADDR_STIMULUS  = 4'h5;
   localparam logic [3:0] ADDR_MODEPTR   = 4'h6;
   localparam int         MISC_LSB       = 4;
   localparam int         TC_LSB         = 2;
   localparam logic [2:0] MISC_NONE      = 3'h0;
   localparam logic [2:0] MISC_MRPTR     = 3'h1;
   localparam logic [2:0] MISC_RX_RESET  = 3'h2;
   localparam logic [2:0] MISC_TX_RESET  = 3'h3;
   localparam logic [2:0] MISC_ERR_RESET = 3'h4;
   localparam logic [2:0] MISC_DB_RESET  = 3'h5;
   localparam logic [2:0] MISC_BRK_START = 3'h6;
   localparam logic [2:0] MISC_BRK_STOP  = 3'h7;
   localparam logic [1:0] TC_ENABLE      = 2'h1;
   localparam logic [1:0] TC_DISABLE     = 2'h2;
   // Status register bit positions.
   localparam int ST_RECEIVE_READY_FLAG = 0;
   localparam int ST_FIFO_FULL_FLAG = 1;
   localparam int ST_TRANSMIT_READY_FLAG = 2;
   localparam int ST_TRANSMIT_EMPTY_FLAG = 3;
   localparam int ST_OVRUN = 4;
   localparam int ST_PARER = 5;
   localparam int ST_FRMER = 6;
   localparam int ST_RXBRK = 7;
   localparam int ST_DBRK  = 8;
   localparam int ST_TXEN  = 9;
   localparam int ST_RXEN  = 10;
   localparam int ST_BREAK = 11;
   // Event bits: break started, break ended, character sent.
   localparam int EV_BRK_ON  = 0;
   localparam int EV_BRK_OFF = 1;
   localparam int EV_TX_DONE = 2;
   localparam int EV_W       = 3;
   localparam int CLK_HZ      = 10_000_000;
   localparam int BAUD_DEF    = 9600;
   localparam int CHAR_BITS   = 10;
endpackage
`default_nettype wire

// ===== rtl/bit_tick.sv
/*
 * Divider giving a one-cycle pulse once per bit time.
 * Assumes a single clock and a synchronous active-low reset.
 */
`default_nettype none
module bit_tick
   import cmd_dec_pkg::*;
#(
   parameter int DIV = CLK_HZ / BAUD_DEF
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   output logic      tick_o
);
   initial begin
      if (DIV < 2 || DIV > 65536) $error("DIV must lie between 2 and 65536.");
   end
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        tick_q;
   logic        tick_d;
   always_comb begin
      tick_d = (cnt_q == 16'(DIV - 1));
      cnt_d  = tick_d ? 16'h0000 : cnt_q + 16'h0001;
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign tick_o = tick_q;
endmodule
`default_nettype wire

// ===== rtl/tx_shifter.sv
/*
 * Serial shifter that sends one 8N1 character per start pulse, on bit ticks.
 * Assumes the start pulse comes only while idle.
 */
`default_nettype none
module tx_shifter
   import cmd_dec_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       tick_i,
   input  wire logic       start_i,
   input  wire logic [7:0] data_i,
   output logic            busy_o,
   output logic            done_o,
   output logic            line_o
);
   logic [8:0] sh_q;
   logic [8:0] sh_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       busy_q;
   logic       busy_d;
   logic       line_q;
   logic       line_d;
   logic       done_q;
   logic       done_d;
   always_comb begin
      sh_d   = sh_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      line_d = line_q;
      done_d = 1'b0;
      if (start_i && !busy_q) begin
         sh_d   = {1'b1, data_i};
         cnt_d  = 4'(CHAR_BITS);
         busy_d = 1'b1;
      end else if (busy_q && tick_i) begin
         if (cnt_q == 4'(CHAR_BITS)) begin
            line_d = 1'b0;
            cnt_d  = cnt_q - 4'h1;
         end else if (cnt_q != 4'h0) begin
            line_d = sh_q[0];
            sh_d   = {1'b1, sh_q[8:1]};
            cnt_d  = cnt_q - 4'h1;
         end else begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sh_q   <= 9'h1FF;
         cnt_q  <= 4'h0;
         busy_q <= 1'b0;
         line_q <= 1'b1;
         done_q <= 1'b0;
      end else begin
         sh_q   <= sh_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         line_q <= line_d;
         done_q <= done_d;
      end
   end
   assign busy_o = busy_q;
   assign done_o = done_q;
   assign line_o = line_q;
endmodule
`default_nettype wire

// ===== tb/cmd_decoder_props.sv
/* Concurrent checks on the command decoder ports.
   Assumes one clock, a synchronous active-low reset and DIV cycles per bit. */
`default_nettype none
module cmd_decoder_props
   import cmd_dec_pkg::*;
#(
   parameter int DIV = 4
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  address_i,
   input wire logic        read_i,
   input wire logic        write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [31:0] readdata_o,
   input wire logic        waitrequest_o,
   input wire logic        clear_to_send_n_i,
   input wire logic        serial_transmit_line_o,
   input wire logic        mode_ptr_o,
   input wire logic        irq_o
);
   localparam int LIM = 10 * DIV;
   localparam int LAG = DIV + 3;
   logic acc;
   logic txen_q, txen_d, brk_q, brk_d;
   int   low_q, low_d, high_q, high_d;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   assign acc = write_i && !waitrequest_o && address_i == ADDR_COMMAND;
   sequence s_cmd(logic [2:0] c);
      acc && writedata_i[6:4] == c;
   endsequence
   always_comb begin
      txen_d = txen_q;
      brk_d  = brk_q;
      if (acc && writedata_i[3:2] == TC_ENABLE) txen_d = 1'b1;
      if (acc && writedata_i[3:2] == TC_DISABLE) txen_d = 1'b0;
      if (acc && writedata_i[6:4] == MISC_BRK_START && txen_q) brk_d = 1'b1;
      if (acc && writedata_i[6:4] == MISC_BRK_STOP) brk_d = 1'b0;
      if (acc && writedata_i[6:4] == MISC_TX_RESET) begin
         txen_d = 1'b0;
         brk_d  = 1'b0;
      end
      low_d  = serial_transmit_line_o ? 0 : low_q + 1;
      high_d = serial_transmit_line_o ? high_q + 1 : 0;
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         txen_q <= 1'b0;
         brk_q  <= 1'b0;
         low_q  <= 0;
         high_q <= 0;
      end else begin
         txen_q <= txen_d;
         brk_q  <= brk_d;
         low_q  <= low_d;
         high_q <= high_d;
      end
   end
   a_wait_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("request not answered after one wait state");
   a_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_ptr_reset: assert property (s_cmd(MISC_MRPTR) |=> !mode_ptr_o)
      else $error("mode pointer not reset");
   a_no_cmd_hold: assert property (s_cmd(MISC_NONE) |=> $stable(mode_ptr_o))
      else $error("empty command changed the mode pointer");
   a_stop_mark: assert property (s_cmd(MISC_BRK_STOP) ##0 (low_q > LIM) |->
      ##[1:2] serial_transmit_line_o) else $error("line not back to mark after stop");
   a_brk_hold: assert property (brk_q && low_q > LIM |=>
      !serial_transmit_line_o || !brk_q) else $error("break ended without command");
   a_brk_start: assert property (s_cmd(MISC_BRK_START) ##0 (txen_q && high_q > LIM)
      |-> ##[1:LAG] !serial_transmit_line_o) else $error("break did not start in time");
   a_brk_refuse: assert property (s_cmd(MISC_BRK_START) ##0 (!txen_q && high_q > LIM)
      |=> serial_transmit_line_o [*8]) else $error("break started while disabled");
endmodule
bind cmd_decoder cmd_decoder_props #(.DIV(DIV)) props_u (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
   .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
   .waitrequest_o(waitrequest_o), .clear_to_send_n_i(clear_to_send_n_i),
   .serial_transmit_line_o(serial_transmit_line_o), .mode_ptr_o(mode_ptr_o), .irq_o(irq_o));
`default_nettype wire

// ===== tb/serial_sink.sv
/* Remote serial receiver: decodes characters and breaks from the line.
   Assumes DIV cycles per bit, one start bit, eight data bits LSB first, one stop. */
`default_nettype none
module serial_sink #(
   parameter int DIV = 4
) (
   input  wire logic  clk_i,
   input  wire logic  rst_n_i,
   input  wire logic  line_i,
   input  wire logic  hold_i,
   output logic       cts_n_o,
   output logic       got_o,
   output logic       brk_o,
   output logic [7:0] data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign cts_n_o = hold_i;
   initial begin
      got_o  = 1'b0;
      brk_o  = 1'b0;
      data_o = 8'h00;
      forever begin
         @(posedge clk_i);
         if (rst_n_i && !line_i) begin
            repeat (DIV / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
               repeat (DIV) @(posedge clk_i);
               data_o[i] <= line_i;
            end
            repeat (DIV) @(posedge clk_i);
            got_o <= line_i;
            brk_o <= !line_i;
            @(posedge clk_i);
            got_o <= 1'b0;
            brk_o <= 1'b0;
            while (!line_i) @(posedge clk_i);
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/uart_misc_command_decoder_bench.sv
/* Bench for the command decoder: bus tasks, a flag model and a serial sink.
   Assumes the package, the decoder and the sink are compiled first. */
`default_nettype none
module uart_misc_command_decoder_bench
   import cmd_dec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DIV = 4;
   localparam int LIM = 12 * DIV;
   logic        clk_i, rst_n_i, read_i, write_i, cts_hold, cts_n, line, mode_ptr, irq;
   logic        got, brk, waitrequest_o;
   logic [3:0]  address_i;
   logic [31:0] writedata_i, readdata_o;
   logic [7:0]  rx_byte;
   int          fails, n_tests, seed, m_st;
   int          ev_q[$];
   cmd_decoder #(.DIV(DIV)) dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .clear_to_send_n_i(cts_n),
      .serial_transmit_line_o(line), .mode_ptr_o(mode_ptr), .irq_o(irq));
   serial_sink #(.DIV(DIV)) sink_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .line_i(line), .hold_i(cts_hold),
      .cts_n_o(cts_n), .got_o(got), .brk_o(brk), .data_o(rx_byte));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (got) ev_q.push_back(int'(rx_byte));
      if (brk) ev_q.push_back(256);
   end
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      address_i   <= a;
      writedata_i <= d;
      write_i     <= wr;
      read_i      <= !wr;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 40);
      q = readdata_o;
      if (n >= 40) fails++;
      write_i <= 1'b0;
      read_i  <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q & m, e & m);
   endtask
   // Top bit stays zero on every command write.
   task automatic do_cmd(input logic [2:0] m, input logic [1:0] t);
      wr(ADDR_COMMAND, {24'h00_0000, 1'b0, m, t, 2'b00});
      if (t == TC_ENABLE) m_st |= 32'h0000_020C;
      case (m)
         MISC_RX_RESET:  m_st &= ~32'h0000_0403;
         MISC_TX_RESET:  m_st &= ~32'h0000_020C;
         MISC_ERR_RESET: m_st &= ~32'h0000_00F0;
         MISC_DB_RESET:  m_st &= ~32'h0000_0100;
         default: ;
      endcase
   endtask
   task automatic wait_ev(input int n);
      int k;
      k = 0;
      while (ev_q.size() < n && k < 2000) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 2000) fails++;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      test_done();
   end
   initial begin
      logic [31:0] stim;
      logic [7:0]  a, b;
      seed = 32'h9c03;
      {rst_n_i, read_i, write_i, cts_hold, address_i, writedata_i} = '0;
      {fails, n_tests, m_st} = '0;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      wr(ADDR_MODEPTR, 32'h0000_0000);
      chk(mode_ptr, 1'b1);
      do_cmd(MISC_NONE, 2'b00);
      chk(mode_ptr, 1'b1);
      do_cmd(MISC_MRPTR, 2'b00);
      chk(mode_ptr, 1'b0);
      for (int i = 0; i < 12; i++) begin
         stim = $random(seed) & 32'h0000_05F3;
         wr(ADDR_STIMULUS, stim);
         m_st |= stim & (m_st[10] ? 32'h0000_05F3 : 32'h0000_05F0);
         do_cmd(3'(i % 6), (i % 6 == 2) ? TC_ENABLE : 2'b00);
         rd_chk(ADDR_STATUS, 32'h0000_07FF, m_st);
      end
      do_cmd(MISC_NONE, TC_ENABLE);
      a = $random(seed);
      b = $random(seed);
      wr(ADDR_TXDATA, {24'h00_0000, a});
      wr(ADDR_TXDATA, {24'h00_0000, b});
      do_cmd(MISC_BRK_START, 2'b00);
      repeat (LIM * 3) @(posedge clk_i);
      do_cmd(MISC_BRK_STOP, 2'b00);
      wait_ev(3);
      chk(ev_q[0], a);
      chk(ev_q[1], 256);
      chk(ev_q[2], b);
      repeat (2 * DIV) @(posedge clk_i);
      rd_chk(ADDR_EVENTS, 32'h0000_0007, 32'h0000_0007);
      chk(irq, 1'b0);
      wr(ADDR_MASK, 32'h0000_0001 << EV_BRK_ON);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b1);
      wr(ADDR_EVENTS, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      rd_chk(ADDR_EVENTS, 32'h0000_0007, 32'h0000_0006);
      wr(ADDR_EVENTS, 32'h0000_0007);
      cts_hold <= 1'b1;
      repeat (LIM) @(posedge clk_i);
      do_cmd(MISC_BRK_START, 2'b00);
      repeat (LIM * 3) @(posedge clk_i);
      do_cmd(MISC_TX_RESET, 2'b00);
      wait_ev(4);
      chk(ev_q[3], 256);
      repeat (2 * DIV) @(posedge clk_i);
      chk(line, 1'b1);
      repeat (LIM) @(posedge clk_i);
      do_cmd(MISC_BRK_START, 2'b00);
      for (int j = 0; j < 3 * DIV; j++) begin
         @(posedge clk_i);
         chk(line, 1'b1);
      end
      rd_chk(4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(4'hF, 32'h0000_FFFF);
      rd_chk(ADDR_STATUS, 32'h0000_05F3, m_st);
      test_done();
   end
endmodule
`default_nettype wire
